/* pml_pkg.sv */
// Purpose : Shared constants for the PLL multiplier and lock status block
// Assumes : 32-bit Avalon-MM register bus, 8-bit registers in byte lane 0
// Notes   : Register index times four gives the byte address
package pml_pkg;

  // Register indices and bus address width
  localparam logic [5:0] IDX_REF_DIV   = 6'h04;
  localparam logic [5:0] IDX_PLL_CTRL6 = 6'h05;
  localparam logic [5:0] IDX_STATUS    = 6'h06;
  localparam logic [5:0] IDX_LOCK_CTRL = 6'h08;
  localparam int unsigned ADDR_W       = 8;

  // Field positions
  localparam int unsigned VCO_SEL_LSB  = 0;
  localparam int unsigned SEL_W        = 5;
  localparam int unsigned CME_BIT      = 5;
  localparam int unsigned IRQ_EN_BIT   = 7;
  localparam int unsigned LOCKED_BIT   = 6;
  localparam int unsigned FLAG_BIT     = 7;
  localparam int unsigned RST_EN_BIT   = 6;

  // Reset values
  localparam logic [4:0] VCO_SEL_RST   = 5'h00;
  localparam logic [4:0] REF_DIV_RST   = 5'h00;

  // Multiplier decode
  localparam int unsigned MULT_W       = 6;
  localparam logic [5:0] MULT_BASE     = 6'h18;

  // Relock settle time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 8;
  localparam logic [7:0]  SETTLE_LAST   = 8'(SETTLE_CYC - 1);
  localparam logic [7:0]  CNT_ONE       = 8'h01;

endpackage

/* pml_lock_if.sv */
// Purpose : Carries lock tracking signals between control and monitor
// Assumes : Single clock domain
// Notes   : ctl drives requests, mon drives lock state
`timescale 1ns/10ps
interface pml_lock_if;
  logic pll_en;
  logic lock_detect;
  logic cfg_change;
  logic locked;
  logic loss_evt;
  logic clk_gate_en;

  modport ctl (output pll_en, output lock_detect, output cfg_change,
               input locked, input loss_evt, input clk_gate_en);
  modport mon (input pll_en, input lock_detect, input cfg_change,
               output locked, output loss_evt, output clk_gate_en);
endinterface

/* pml_lock_mon.sv */
// Purpose : Tracks PLL lock, flags loss of lock, gates the PLL output clock
// Assumes : Raw lock detect is synchronous to ref_clk
// Notes   : Lock is indicated only after detect has held for the settle time
`timescale 1ns/10ps
module pml_lock_mon (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Lock signals
  pml_lock_if.mon   lk
);

  logic                         locked_r;
  logic                         locked_nxt;
  logic                         loss_r;
  logic                         loss_nxt;
  logic                         gate_r;
  logic                         gate_nxt;
  logic [pml_pkg::CNT_W-1:0]    cnt_r;
  logic [pml_pkg::CNT_W-1:0]    cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    locked_nxt = locked_r;
    cnt_nxt    = cnt_r;
    loss_nxt   = 1'b0;
    if (!lk.pll_en) begin
      locked_nxt = 1'b0;
      cnt_nxt    = '0;
    end else if (lk.cfg_change) begin
      locked_nxt = 1'b0;
      cnt_nxt    = '0;
    end else if (locked_r) begin
      if (!lk.lock_detect) begin
        locked_nxt = 1'b0;
        loss_nxt   = 1'b1;
        cnt_nxt    = '0;
      end
    end else if (lk.lock_detect) begin
      if (cnt_r == pml_pkg::SETTLE_LAST) begin
        locked_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + pml_pkg::CNT_ONE;
      end
    end else begin
      cnt_nxt = '0;
    end
    gate_nxt = lk.pll_en && locked_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_r <= 1'b0;
      loss_r   <= 1'b0;
      gate_r   <= 1'b0;
      cnt_r    <= '0;
    end else begin
      locked_r <= locked_nxt;
      loss_r   <= loss_nxt;
      gate_r   <= gate_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign lk.locked      = locked_r;
  assign lk.loss_evt    = loss_r;
  assign lk.clk_gate_en = gate_r;

endmodule

/* pml_top.sv */
// Purpose : PLL multiplier select, lock status and loss-of-lock routing
// Assumes : Avalon-MM slave with one wait cycle per access
// Notes   : Registers occupy byte lane 0; upper bits read zero
// How it works
// - Multiply factor equals 24 plus code
// - Sticky flag sets when acquired lock lost
// - Reset or write-one clears flag; zero ignored
// - Interrupt request when flag set and enabled
// - Reset request when flag set and enabled
// - Divider or multiplier change clears lock indication
// - Output clock gated while enabled and unlocked
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
module pml_top (
  // Clock and reset
  input  wire  logic                         ref_clk,
  input  wire  logic                         rst_n,
  // Avalon-MM slave
  input  wire  logic [pml_pkg::ADDR_W-1:0]   avs_address,
  input  wire  logic                         avs_read,
  input  wire  logic                         avs_write,
  input  wire  logic [31:0]                  avs_writedata,
  input  wire  logic [3:0]                   avs_byteenable,
  output logic       [31:0]                  avs_readdata,
  output logic                               avs_waitrequest,
  // PLL side
  input  wire  logic                         pll_en,
  input  wire  logic                         pll_lock_detect,
  output logic       [pml_pkg::MULT_W-1:0]   vco_mult_factor,
  output logic       [pml_pkg::SEL_W-1:0]    ref_divider_sel,
  output logic                               pll_locked,
  output logic                               pll_clk_enable,
  // Clock monitor and requests
  output logic                               ext_clock_monitor_en,
  output logic                               lock_loss_irq,
  output logic                               lock_loss_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [pml_pkg::SEL_W-1:0]   vco_sel_r;
  logic [pml_pkg::SEL_W-1:0]   vco_sel_nxt;
  logic [pml_pkg::SEL_W-1:0]   ref_div_r;
  logic [pml_pkg::SEL_W-1:0]   ref_div_nxt;
  logic                        cme_r;
  logic                        cme_nxt;
  logic                        irq_en_r;
  logic                        irq_en_nxt;
  logic                        rst_en_r;
  logic                        rst_en_nxt;
  logic                        flag_r;
  logic                        flag_nxt;
  logic [pml_pkg::MULT_W-1:0]  mult_r;
  logic [pml_pkg::MULT_W-1:0]  mult_nxt;
  logic                        irq_r;
  logic                        irq_nxt;
  logic                        rreq_r;
  logic                        rreq_nxt;
  logic [31:0]                 rdata_r;
  logic [31:0]                 rdata_nxt;
  logic                        wait_r;
  logic                        wait_nxt;
  logic                        locked_out_r;
  logic                        gate_out_r;
  logic [5:0]                  idx;
  logic                        req;
  logic                        commit_wr;
  logic [7:0]                  wbyte;
  logic [7:0]                  rbyte;

  pml_lock_if lk ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign idx       = avs_address[pml_pkg::ADDR_W-1:2];
  assign req       = avs_read || avs_write;
  assign commit_wr = avs_write && !wait_r && avs_byteenable[0];
  assign wbyte     = avs_writedata[7:0];

  always_comb begin
    rbyte = 8'h00;
    case (idx)
      pml_pkg::IDX_REF_DIV: begin
        rbyte[pml_pkg::SEL_W-1:0] = ref_div_r;
      end
      pml_pkg::IDX_PLL_CTRL6: begin
        rbyte[pml_pkg::IRQ_EN_BIT]             = irq_en_r;
        rbyte[pml_pkg::CME_BIT]                = cme_r;
        rbyte[pml_pkg::SEL_W-1:0]              = vco_sel_r;
      end
      pml_pkg::IDX_STATUS: begin
        rbyte[pml_pkg::FLAG_BIT]               = flag_r;
        rbyte[pml_pkg::LOCKED_BIT]             = lk.locked;
      end
      pml_pkg::IDX_LOCK_CTRL: begin
        rbyte[pml_pkg::RST_EN_BIT]             = rst_en_r;
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer
  always_comb begin
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    if (req && wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_comb begin
    vco_sel_nxt = vco_sel_r;
    ref_div_nxt = ref_div_r;
    cme_nxt     = cme_r;
    irq_en_nxt  = irq_en_r;
    rst_en_nxt  = rst_en_r;
    if (commit_wr) begin
      case (idx)
        pml_pkg::IDX_REF_DIV: begin
          ref_div_nxt = wbyte[pml_pkg::SEL_W-1:0];
        end
        pml_pkg::IDX_PLL_CTRL6: begin
          irq_en_nxt  = wbyte[pml_pkg::IRQ_EN_BIT];
          cme_nxt     = wbyte[pml_pkg::CME_BIT];
          vco_sel_nxt = wbyte[pml_pkg::VCO_SEL_LSB +: pml_pkg::SEL_W];
        end
        pml_pkg::IDX_LOCK_CTRL: begin
          rst_en_nxt  = wbyte[pml_pkg::RST_EN_BIT];
        end
        default: begin
          rst_en_nxt  = rst_en_r;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_sel_r <= pml_pkg::VCO_SEL_RST;
      ref_div_r <= pml_pkg::REF_DIV_RST;
      cme_r     <= 1'b0;
      irq_en_r  <= 1'b0;
      rst_en_r  <= 1'b0;
    end else begin
      vco_sel_r <= vco_sel_nxt;
      ref_div_r <= ref_div_nxt;
      cme_r     <= cme_nxt;
      irq_en_r  <= irq_en_nxt;
      rst_en_r  <= rst_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock monitor
  assign lk.pll_en      = pll_en;
  assign lk.lock_detect = pll_lock_detect;
  assign lk.cfg_change  = (vco_sel_nxt != vco_sel_r) || (ref_div_nxt != ref_div_r);

  pml_lock_mon u_lock_mon (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .lk      (lk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flag and request routing
  always_comb begin
    flag_nxt = flag_r;
    if (commit_wr && (idx == pml_pkg::IDX_STATUS) && wbyte[pml_pkg::FLAG_BIT]) begin
      flag_nxt = 1'b0;
    end
    if (lk.loss_evt) begin
      flag_nxt = 1'b1;
    end
    irq_nxt  = flag_nxt && irq_en_nxt;
    rreq_nxt = flag_nxt && rst_en_nxt;
    mult_nxt = pml_pkg::MULT_BASE + {1'b0, vco_sel_nxt};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r       <= 1'b0;
      irq_r        <= 1'b0;
      rreq_r       <= 1'b0;
      mult_r       <= pml_pkg::MULT_BASE;
      locked_out_r <= 1'b0;
      gate_out_r   <= 1'b0;
    end else begin
      flag_r       <= flag_nxt;
      irq_r        <= irq_nxt;
      rreq_r       <= rreq_nxt;
      mult_r       <= mult_nxt;
      locked_out_r <= lk.locked;
      gate_out_r   <= lk.clk_gate_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata         = rdata_r;
  assign avs_waitrequest      = wait_r;
  assign vco_mult_factor      = mult_r;
  assign ref_divider_sel      = ref_div_r;
  assign pll_locked           = locked_out_r;
  assign pll_clk_enable       = gate_out_r;
  assign ext_clock_monitor_en = cme_r;
  assign lock_loss_irq        = irq_r;
  assign lock_loss_reset_req  = rreq_r;

endmodule

/* pml_asserts.sv */
// Purpose : Concurrent checks on the PLL multiplier and lock status block
// Assumes : Bound to pml_top, one clock domain
// Notes   : Enables and multiplier are tracked from bus writes
`timescale 1ns/10ps
module pml_asserts (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic       avs_waitrequest,
  // PLL side and requests
  input wire logic       pll_en,
  input wire logic       pll_lock_detect,
  input wire logic [5:0] vco_mult_factor,
  input wire logic [4:0] ref_divider_sel,
  input wire logic       pll_locked,
  input wire logic       pll_clk_enable,
  input wire logic       lock_loss_irq,
  input wire logic       lock_loss_reset_req
);
  logic       wr_ok;
  logic [5:0] idx;
  logic       irq_en_r, irq_en_nxt, rst_en_r, rst_en_nxt;
  logic [5:0] mult_r, mult_nxt;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign idx   = avs_address[7:2];
  always_comb begin
    irq_en_nxt = irq_en_r;
    rst_en_nxt = rst_en_r;
    mult_nxt   = mult_r;
    if (wr_ok && idx == pml_pkg::IDX_PLL_CTRL6) begin
      irq_en_nxt = avs_writedata[7];
      mult_nxt   = pml_pkg::MULT_BASE + {1'b0, avs_writedata[4:0]};
    end
    if (wr_ok && idx == pml_pkg::IDX_LOCK_CTRL)
      rst_en_nxt = avs_writedata[6];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_r <= 1'b0;
      rst_en_r <= 1'b0;
      mult_r   <= pml_pkg::MULT_BASE;
    end else begin
      irq_en_r <= irq_en_nxt;
      rst_en_r <= rst_en_nxt;
      mult_r   <= mult_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_mult_tracks:
    assert property (!$past(wr_ok) |-> vco_mult_factor == mult_r)
    else $error("multiply factor wrong");
  a_loss_requests:
    assert property ($fell(pll_lock_detect) && pll_locked && pll_en |-> ##[1:3]
      (lock_loss_irq == irq_en_r && lock_loss_reset_req == rst_en_r))
    else $error("requests missing after loss");
  a_irq_needs_en:
    assert property (lock_loss_irq |-> irq_en_r || $past(irq_en_r))
    else $error("interrupt without enable");
  a_rst_needs_en:
    assert property (lock_loss_reset_req |-> rst_en_r || $past(rst_en_r))
    else $error("reset request without enable");
  a_flag_sticky:
    assert property (lock_loss_irq && irq_en_r && !wr_ok |=> lock_loss_irq)
    else $error("flag dropped without clear");
  a_gate_unlocked:
    assert property (!pll_locked |-> !pll_clk_enable)
    else $error("clock not gated while unlocked");
  a_cfg_clears:
    assert property (wr_ok && pll_locked && ((idx == pml_pkg::IDX_PLL_CTRL6 &&
      pml_pkg::MULT_BASE + {1'b0, avs_writedata[4:0]} != vco_mult_factor) ||
      (idx == pml_pkg::IDX_REF_DIV && avs_writedata[4:0] != ref_divider_sel))
      |-> ##[1:3] !pll_locked)
    else $error("lock kept after config change");
endmodule
bind pml_top pml_asserts chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .pll_en(pll_en),
  .pll_lock_detect(pll_lock_detect), .vco_mult_factor(vco_mult_factor),
  .ref_divider_sel(ref_divider_sel), .pll_locked(pll_locked),
  .pll_clk_enable(pll_clk_enable), .lock_loss_irq(lock_loss_irq),
  .lock_loss_reset_req(lock_loss_reset_req));

/* pml_top_tb.sv */
// Purpose : Self-checking bench for the PLL multiplier and lock status block
// Assumes : One wait state per bus access, lock after 100 cycles of detect
// Notes   : Each scenario is one task
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module pml_top_tb;
  logic        ref_clk         = 1'b0;
  logic        rst_n           = 1'b0;
  logic [7:0]  avs_address     = 8'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [3:0]  avs_byteenable  = 4'h0;
  logic        pll_en          = 1'b0;
  logic        pll_lock_detect = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, pll_locked, pll_clk_enable, ext_clock_monitor_en;
  logic [5:0]  vco_mult_factor;
  logic [4:0]  ref_divider_sel;
  logic        lock_loss_irq, lock_loss_reset_req;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  pml_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pll_en(pll_en), .pll_lock_detect(pll_lock_detect),
    .vco_mult_factor(vco_mult_factor), .ref_divider_sel(ref_divider_sel),
    .pll_locked(pll_locked), .pll_clk_enable(pll_clk_enable),
    .ext_clock_monitor_en(ext_clock_monitor_en), .lock_loss_irq(lock_loss_irq),
    .lock_loss_reset_req(lock_loss_reset_req));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) bad_count++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("factor", 6'h18, vco_mult_factor);
    rdr(8'h18);
    `CHK("status", 32'h0, rd);
    wr(8'h3C, 8'hFF);
    rdr(8'h3C);
    `CHK("unmapped", 32'h0, rd);
    `CHK("factor", 6'h18, vco_mult_factor);
    $display("t_reset done");
  endtask
  task automatic t_mult();
    for (int i = 0; i < 32; i++) begin
      bus(1'b1, 8'h14, {2'b00, i[0], i[4:0]}, 4'h1);
      @(posedge ref_clk);
      `CHK("factor", 6'h18 + 6'(i), vco_mult_factor);
      `CHK("monitor", i[0], ext_clock_monitor_en);
    end
    bus(1'b1, 8'h14, 8'h05, 4'h0);
    rdr(8'h14);
    `CHK("c6", 32'h3F, rd);
    `CHK("factor", 6'h37, vco_mult_factor);
    $display("t_mult done");
  endtask
  task automatic t_lock();
    pll_en          <= 1'b1;
    pll_lock_detect <= 1'b1;
    repeat (50) @(posedge ref_clk);
    `CHK("clk_en", 1'b0, pll_clk_enable);
    repeat (55) @(posedge ref_clk);
    `CHK("clk_en", 1'b1, pll_clk_enable);
    rdr(8'h18);
    `CHK("status", 32'h40, rd);
    $display("t_lock done");
  endtask
  task automatic t_loss();
    wr(8'h14, 8'h9F);
    wr(8'h20, 8'h40);
    `CHK("monitor", 1'b0, ext_clock_monitor_en);
    `CHK("locked", 1'b1, pll_locked);
    pll_lock_detect <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK("clk_en", 1'b0, pll_clk_enable);
    `CHK("irq", 1'b1, lock_loss_irq);
    `CHK("rst_req", 1'b1, lock_loss_reset_req);
    pll_lock_detect <= 1'b1;
    wr(8'h18, 8'h00);
    rdr(8'h18);
    `CHK("flag", 32'h80, rd & 32'h80);
    wr(8'h18, 8'h80);
    rdr(8'h18);
    `CHK("flag", 32'h0, rd & 32'h80);
    `CHK("irq", 1'b0, lock_loss_irq);
    $display("t_loss done");
  endtask
  task automatic t_cfg();
    repeat (105) @(posedge ref_clk);
    wr(8'h14, 8'h85);
    repeat (2) @(posedge ref_clk);
    `CHK("locked", 1'b0, pll_locked);
    `CHK("factor", 6'h1D, vco_mult_factor);
    repeat (105) @(posedge ref_clk);
    wr(8'h10, 8'h03);
    repeat (2) @(posedge ref_clk);
    `CHK("locked", 1'b0, pll_locked);
    `CHK("divider", 5'h03, ref_divider_sel);
    rdr(8'h18);
    `CHK("status", 32'h0, rd);
    $display("t_cfg done");
  endtask
  task automatic t_off();
    wr(8'h14, 8'h05);
    wr(8'h20, 8'h00);
    repeat (105) @(posedge ref_clk);
    `CHK("locked", 1'b1, pll_locked);
    pll_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("clk_en", 1'b0, pll_clk_enable);
    `CHK("locked", 1'b0, pll_locked);
    rdr(8'h18);
    `CHK("status", 32'h0, rd);
    pll_en <= 1'b1;
    repeat (105) @(posedge ref_clk);
    `CHK("clk_en", 1'b1, pll_clk_enable);
    pll_lock_detect <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK("irq", 1'b0, lock_loss_irq);
    `CHK("rst_req", 1'b0, lock_loss_reset_req);
    rdr(8'h18);
    `CHK("status", 32'h80, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdr(8'h18);
    `CHK("status", 32'h0, rd);
    `CHK("factor", 6'h18, vco_mult_factor);
    $display("t_off done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_mult();
    t_lock();
    t_loss();
    t_cfg();
    t_off();
    final_report();
  end
endmodule
